// ==== core/cie_core.sv ====
`timescale 1ns/100ps
`default_nettype none
module cie_core (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Program memory, asynchronous read
    output logic      [14:0] pm_addr,
    input  wire logic [7:0]  pm_data,
    // Data memory, asynchronous read
    output logic      [7:0]  dm_addr,
    output logic      [7:0]  dm_wdata,
    output logic             dm_we,
    input  wire logic [7:0]  dm_rdata,
    // Interrupt side
    input  wire logic [14:0] vector_addr,
    input  wire logic        int_enable_clear,
    output logic             global_interrupt_enable,
    output logic             clear_soft_irq_pending,
    // Core state
    output logic      [7:0]  acc,
    output logic             carry,
    output logic             half_carry_flag
);

    cie_pkg::cie_st_t state_q, state_d;
    logic [14:0] pc_q, pc_d;
    logic [7:0]  a_q, a_d, b_q, b_d, x_q, x_d;
    logic [7:0]  stack_pointer_q, stack_pointer_d;
    logic [7:0]  opc_q, opc_d, b1_q, b1_d, b2_q, b2_d;
    logic        c_q, c_d, hcf_q, hcf_d, ien_q, ien_d, skip_q, skip_d;
    logic        wr_en, soft_clr;
    logic [7:0]  wr_data;

    // Opcode length in bytes
    function automatic logic [1:0] ins_len(input logic [7:0] opb);
        logic [1:0] m;
        logic       ext;
        m   = opb[7:6];
        ext = (m == cie_pkg::MODE_IMM) || (m == cie_pkg::MODE_DIR);
        case (cie_pkg::cie_op_t'(opb[5:0]))
            cie_pkg::OP_ADD, cie_pkg::OP_ADC, cie_pkg::OP_SUBTRACT_WITH_CARRY_OP,
            cie_pkg::OP_AND, cie_pkg::OP_OR, cie_pkg::OP_XOR, cie_pkg::OP_LOAD,
            cie_pkg::OP_DO_IF_EQUAL, cie_pkg::OP_DO_IF_NOT_EQUAL,
            cie_pkg::OP_DO_IF_GREATER:
                ins_len = ext ? 2'h2 : 2'h1;
            cie_pkg::OP_EXCHANGE:
                ins_len = (m == cie_pkg::MODE_DIR) ? 2'h2 : 2'h1;
            cie_pkg::OP_AND_IMMEDIATE_SKIP_ZERO, cie_pkg::OP_POINTER_LOW_NIBBLE_COMPARE,
            cie_pkg::OP_DECREMENT_SKIP_ZERO, cie_pkg::OP_SHORT_RELATIVE_JUMP:
                ins_len = 2'h2;
            cie_pkg::OP_BIT_SET_OP, cie_pkg::OP_BIT_CLEAR_OP, cie_pkg::OP_BIT_TEST_OP:
                ins_len = (m == cie_pkg::MODE_DIR) ? 2'h3 : 2'h2;
            cie_pkg::OP_DIRECT_EQUAL, cie_pkg::OP_SEGMENT_ABSOLUTE_JUMP,
            cie_pkg::OP_SEGMENT_SUBROUTINE_CALL, cie_pkg::OP_LONG_ABSOLUTE_JUMP,
            cie_pkg::OP_LONG_SUBROUTINE_CALL:
                ins_len = 2'h3;
            default:
                ins_len = 2'h1;
        endcase
    endfunction : ins_len

    // Decode of the held opcode
    cie_pkg::cie_op_t op;
    logic [1:0] mode;
    logic       in_exec, second, is_bit, is_auto, is_call, is_ret, uses_stack;
    assign op      = cie_pkg::cie_op_t'(opc_q[5:0]);
    assign mode    = opc_q[7:6];
    assign in_exec = (state_q == cie_pkg::ST_EXEC) || (state_q == cie_pkg::ST_EXEC2);
    assign second  = (state_q == cie_pkg::ST_EXEC2);
    assign is_bit  = (op == cie_pkg::OP_BIT_SET_OP) || (op == cie_pkg::OP_BIT_CLEAR_OP)
                  || (op == cie_pkg::OP_BIT_TEST_OP);
    assign is_auto = (op == cie_pkg::OP_LOAD_AUTO) || (op == cie_pkg::OP_EXCHANGE_AUTO);
    assign is_call = (op == cie_pkg::OP_SEGMENT_SUBROUTINE_CALL)
                  || (op == cie_pkg::OP_LONG_SUBROUTINE_CALL);
    assign is_ret  = (op == cie_pkg::OP_SUB_RETURN) || (op == cie_pkg::OP_INTERRUPT_RETURN);
    assign uses_stack = is_call || is_ret || (op == cie_pkg::OP_PUSH) || (op == cie_pkg::OP_POP);

    // Pointer selection and auto step
    logic [7:0] ptr, ptr_next;
    assign ptr      = mode[0] ? x_q : b_q;
    assign ptr_next = mode[1] ? ptr - cie_pkg::STEP_ONE : ptr + cie_pkg::STEP_ONE;

    // Stack addressing: push at SP, pop at SP+1, frames of two
    logic [7:0] stk_addr;
    assign stk_addr = (op == cie_pkg::OP_PUSH) ? stack_pointer_q :
                      (op == cie_pkg::OP_POP)  ? stack_pointer_q + cie_pkg::STEP_ONE :
                      is_call ? (second ? stack_pointer_q - cie_pkg::STEP_ONE : stack_pointer_q) :
                      (second ? stack_pointer_q + cie_pkg::STEP_ONE
                              : stack_pointer_q + cie_pkg::STACK_FRAME);

    // Data memory address
    logic [7:0] mem_addr, dir_addr;
    assign dir_addr = is_bit ? b2_q : b1_q;
    assign mem_addr = uses_stack ? stk_addr :
                      is_auto ? ptr :
                      (op == cie_pkg::OP_DECREMENT_SKIP_ZERO) ? {cie_pkg::REG_PAGE, b1_q[3:0]} :
                      (op == cie_pkg::OP_DIRECT_EQUAL) ? b1_q :
                      (mode == cie_pkg::MODE_DIR) ? dir_addr : b_q;

    // Pointers live here, so their addresses are served locally
    logic hit_x, hit_s, hit_b;
    logic [7:0] rd, opnd;
    assign hit_x = (mem_addr == cie_pkg::ADDR_X);
    assign hit_s = (mem_addr == cie_pkg::ADDR_STACK);
    assign hit_b = (mem_addr == cie_pkg::ADDR_B);
    assign rd    = hit_x ? x_q : hit_s ? stack_pointer_q : hit_b ? b_q : dm_rdata;
    assign opnd  = (mode == cie_pkg::MODE_IMM) ? b1_q : rd;

    // Data memory port
    assign dm_addr  = mem_addr;
    assign dm_wdata = wr_data;
    assign dm_we    = wr_en && !(hit_x || hit_s || hit_b);

    // Program memory port: fetch, table read or vector read
    assign pm_addr = !in_exec ? pc_q :
                     (op == cie_pkg::OP_VECTOR_TO_SERVICE) ?
                         (second ? vector_addr + cie_pkg::VEC_NEXT : vector_addr) :
                     {pc_q[14:8], a_q};

    // Adder shared by add and subtract
    logic       cin;
    logic [7:0] opx, bit_mask, dec_val, bcd_val;
    logic [8:0] sum9;
    logic [4:0] sum5;
    assign cin  = (op == cie_pkg::OP_ADC || op == cie_pkg::OP_SUBTRACT_WITH_CARRY_OP) && c_q;
    assign opx  = (op == cie_pkg::OP_SUBTRACT_WITH_CARRY_OP) ? ~opnd : opnd;
    assign sum9 = {1'b0, a_q} + {1'b0, opx} + {8'h00, cin};
    assign sum5 = {1'b0, a_q[3:0]} + {1'b0, opx[3:0]} + {4'h0, cin};
    assign bit_mask = cie_pkg::STEP_ONE << b1_q[2:0];
    assign dec_val  = rd - cie_pkg::STEP_ONE;
    assign bcd_val  = a_q - (c_q ? 8'h00 : cie_pkg::BCD_HI_FIX)
                          - (hcf_q ? 8'h00 : cie_pkg::BCD_LO_FIX);

    // Relative target and its legal span
    logic        rel_ok;
    logic [14:0] rel_target;
    assign rel_ok = ($signed(b1_q) >= cie_pkg::REL_MIN) && ($signed(b1_q) <= cie_pkg::REL_MAX);
    assign rel_target = pc_q - cie_pkg::REL_BASE + {{7{b1_q[7]}}, b1_q};

    // Sequencer and execution
    always_comb begin
        state_d = state_q;
        pc_d    = pc_q;
        a_d     = a_q;
        b_d     = b_q;
        x_d     = x_q;
        stack_pointer_d = stack_pointer_q;
        opc_d   = opc_q;
        b1_d    = b1_q;
        b2_d    = b2_q;
        c_d     = c_q;
        hcf_d   = hcf_q;
        ien_d   = ien_q && !int_enable_clear;
        skip_d  = skip_q;
        wr_en   = 1'b0;
        wr_data = a_q;
        soft_clr = 1'b0;
        case (state_q)
            cie_pkg::ST_OPCODE: begin
                opc_d = pm_data;
                pc_d  = pc_q + cie_pkg::PC_STEP;
                if (ins_len(pm_data) != 2'h1) begin
                    state_d = cie_pkg::ST_BYTE1;
                end else if (skip_q) begin
                    skip_d = 1'b0;
                end else begin
                    state_d = cie_pkg::ST_EXEC;
                end
            end
            cie_pkg::ST_BYTE1: begin
                b1_d = pm_data;
                pc_d = pc_q + cie_pkg::PC_STEP;
                if (ins_len(opc_q) == 2'h3) begin
                    state_d = cie_pkg::ST_BYTE2;
                end else if (skip_q) begin
                    skip_d  = 1'b0;
                    state_d = cie_pkg::ST_OPCODE;
                end else begin
                    state_d = cie_pkg::ST_EXEC;
                end
            end
            cie_pkg::ST_BYTE2: begin
                b2_d    = pm_data;
                pc_d    = pc_q + cie_pkg::PC_STEP;
                skip_d  = 1'b0;
                state_d = skip_q ? cie_pkg::ST_OPCODE : cie_pkg::ST_EXEC;
            end
            cie_pkg::ST_EXEC: begin
                state_d = cie_pkg::ST_OPCODE;
                case (op)
                    cie_pkg::OP_ADD: a_d = sum9[7:0];
                    cie_pkg::OP_ADC, cie_pkg::OP_SUBTRACT_WITH_CARRY_OP: begin
                        a_d   = sum9[7:0];
                        c_d   = sum9[8];
                        hcf_d = sum5[4];
                    end
                    cie_pkg::OP_AND: a_d = a_q & opnd;
                    cie_pkg::OP_OR: a_d = a_q | opnd;
                    cie_pkg::OP_XOR: a_d = a_q ^ opnd;
                    cie_pkg::OP_LOAD: a_d = opnd;
                    cie_pkg::OP_EXCHANGE: begin
                        a_d   = rd;
                        wr_en = 1'b1;
                    end
                    cie_pkg::OP_AND_IMMEDIATE_SKIP_ZERO: skip_d = (a_q & b1_q) == 8'h00;
                    cie_pkg::OP_DO_IF_EQUAL: skip_d = (a_q != opnd);
                    cie_pkg::OP_DO_IF_NOT_EQUAL: skip_d = (a_q == opnd);
                    cie_pkg::OP_DO_IF_GREATER: skip_d = !(a_q > opnd);
                    cie_pkg::OP_DIRECT_EQUAL: skip_d = (rd != b2_q);
                    cie_pkg::OP_POINTER_LOW_NIBBLE_COMPARE: skip_d = (b_q[3:0] == b1_q[3:0]);
                    cie_pkg::OP_DECREMENT_SKIP_ZERO: begin
                        wr_en   = 1'b1;
                        wr_data = dec_val;
                        skip_d  = (dec_val == 8'h00);
                    end
                    cie_pkg::OP_BIT_SET_OP: begin
                        wr_en   = 1'b1;
                        wr_data = rd | bit_mask;
                    end
                    cie_pkg::OP_BIT_CLEAR_OP: begin
                        wr_en   = 1'b1;
                        wr_data = rd & ~bit_mask;
                    end
                    cie_pkg::OP_BIT_TEST_OP: skip_d = (rd & bit_mask) == 8'h00;
                    cie_pkg::OP_CLEAR_SOFT_IRQ_PENDING: soft_clr = 1'b1;
                    cie_pkg::OP_LOAD_AUTO, cie_pkg::OP_EXCHANGE_AUTO: begin
                        a_d   = rd;
                        wr_en = (op == cie_pkg::OP_EXCHANGE_AUTO);
                        if (mode[0]) begin
                            x_d = ptr_next;
                        end else begin
                            b_d = ptr_next;
                        end
                    end
                    cie_pkg::OP_PROGRAM_BYTE_LOAD: a_d = pm_data;
                    cie_pkg::OP_DECIMAL_ADJUST: a_d = bcd_val;
                    cie_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY: {a_d, c_d} = {c_q, a_q};
                    cie_pkg::OP_ROTATE_LEFT_THROUGH_CARRY: {c_d, a_d} = {a_q, c_q};
                    cie_pkg::OP_SET_CARRY: {c_d, hcf_d} = 2'h3;
                    cie_pkg::OP_RESET_CARRY: {c_d, hcf_d} = 2'h0;
                    cie_pkg::OP_DO_IF_CARRY_SET: skip_d = !c_q;
                    cie_pkg::OP_DO_IF_CARRY_CLEAR: skip_d = c_q;
                    cie_pkg::OP_PUSH: begin
                        wr_en = 1'b1;
                        stack_pointer_d = stack_pointer_q - cie_pkg::STEP_ONE;
                    end
                    cie_pkg::OP_POP: begin
                        a_d = rd;
                        stack_pointer_d = stack_pointer_q + cie_pkg::STEP_ONE;
                    end
                    cie_pkg::OP_VECTOR_TO_SERVICE: begin
                        pc_d[14:8] = pm_data[6:0];
                        state_d    = cie_pkg::ST_EXEC2;
                    end
                    cie_pkg::OP_SEGMENT_ABSOLUTE_JUMP: pc_d[11:0] = {b1_q[3:0], b2_q};
                    cie_pkg::OP_LONG_ABSOLUTE_JUMP: pc_d = {b1_q[6:0], b2_q};
                    cie_pkg::OP_SHORT_RELATIVE_JUMP: pc_d = rel_ok ? rel_target : pc_q;
                    cie_pkg::OP_TABLE_INDIRECT_JUMP: pc_d[7:0] = pm_data;
                    cie_pkg::OP_SEGMENT_SUBROUTINE_CALL, cie_pkg::OP_LONG_SUBROUTINE_CALL: begin
                        wr_en   = 1'b1;
                        wr_data = pc_q[7:0];
                        state_d = cie_pkg::ST_EXEC2;
                    end
                    cie_pkg::OP_SUB_RETURN, cie_pkg::OP_INTERRUPT_RETURN: begin
                        pc_d[7:0] = rd;
                        state_d   = cie_pkg::ST_EXEC2;
                    end
                    default: ;
                endcase
            end
            cie_pkg::ST_EXEC2: begin
                state_d = cie_pkg::ST_OPCODE;
                case (op)
                    cie_pkg::OP_VECTOR_TO_SERVICE: pc_d[7:0] = pm_data;
                    cie_pkg::OP_SEGMENT_SUBROUTINE_CALL, cie_pkg::OP_LONG_SUBROUTINE_CALL: begin
                        wr_en   = 1'b1;
                        wr_data = {1'b0, pc_q[14:8]};
                        stack_pointer_d = stack_pointer_q - cie_pkg::STACK_FRAME;
                        if (op == cie_pkg::OP_LONG_SUBROUTINE_CALL) begin
                            pc_d = {b1_q[6:0], b2_q};
                        end else begin
                            pc_d[11:0] = {b1_q[3:0], b2_q};
                        end
                    end
                    cie_pkg::OP_SUB_RETURN, cie_pkg::OP_INTERRUPT_RETURN: begin
                        pc_d[14:8] = rd[6:0];
                        stack_pointer_d = stack_pointer_q + cie_pkg::STACK_FRAME;
                        ien_d = ien_d || (op == cie_pkg::OP_INTERRUPT_RETURN);
                    end
                    default: ;
                endcase
            end
            default: state_d = cie_pkg::ST_OPCODE;
        endcase
        // Writes that land on a pointer address update the local copy
        x_d = (wr_en && hit_x) ? wr_data : x_d;
        stack_pointer_d = (wr_en && hit_s) ? wr_data : stack_pointer_d;
        b_d = (wr_en && hit_b) ? wr_data : b_d;
    end

    // State registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q <= cie_pkg::ST_OPCODE;
            pc_q    <= cie_pkg::PC_RST;
            a_q     <= cie_pkg::ACC_RST;
            b_q     <= cie_pkg::PTR_RST;
            x_q     <= cie_pkg::PTR_RST;
            stack_pointer_q <= cie_pkg::STACK_RST;
            opc_q   <= 8'h00;
            b1_q    <= 8'h00;
            b2_q    <= 8'h00;
            c_q     <= 1'b0;
            hcf_q   <= 1'b0;
            ien_q   <= 1'b0;
            skip_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            pc_q    <= pc_d;
            a_q     <= a_d;
            b_q     <= b_d;
            x_q     <= x_d;
            stack_pointer_q <= stack_pointer_d;
            opc_q   <= opc_d;
            b1_q    <= b1_d;
            b2_q    <= b2_d;
            c_q     <= c_d;
            hcf_q   <= hcf_d;
            ien_q   <= ien_d;
            skip_q  <= skip_d;
        end
    end

    // Status outputs
    assign global_interrupt_enable = ien_q;
    assign clear_soft_irq_pending  = soft_clr;
    assign acc             = a_q;
    assign carry           = c_q;
    assign half_carry_flag = hcf_q;

endmodule : cie_core
`default_nettype wire

// ==== core/cie_pkg.sv ====
package cie_pkg;

    // Widths and values after reset
    localparam int          PC_W          = 15;
    localparam logic [14:0] PC_RST        = 15'h0000;
    localparam logic [7:0]  ACC_RST       = 8'h00;
    localparam logic [7:0]  PTR_RST       = 8'h00;
    localparam logic [7:0]  STACK_RST     = 8'h2F;

    // Operand modes held in opcode bits 7:6
    localparam logic [1:0]  MODE_PTR      = 2'h0;
    localparam logic [1:0]  MODE_IMM      = 2'h1;
    localparam logic [1:0]  MODE_DIR      = 2'h2;

    // Register space and the pointers inside it
    localparam logic [3:0]  REG_PAGE      = 4'hF;
    localparam logic [7:0]  ADDR_X        = 8'hFC;
    localparam logic [7:0]  ADDR_STACK    = 8'hFD;
    localparam logic [7:0]  ADDR_B        = 8'hFE;

    // Stack, jump and decimal constants
    localparam logic [7:0]  STEP_ONE      = 8'h01;
    localparam logic [7:0]  STACK_FRAME   = 8'h02;
    localparam logic [14:0] VEC_NEXT      = 15'h0001;
    localparam logic [14:0] PC_STEP       = 15'h0001;
    localparam logic [14:0] REL_BASE      = 15'h0002;
    localparam int          REL_MIN       = -31;
    localparam int          REL_MAX       = 32;
    localparam logic [7:0]  BCD_HI_FIX    = 8'h60;
    localparam logic [7:0]  BCD_LO_FIX    = 8'h06;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_OPCODE = 3'b000,
        ST_BYTE1  = 3'b001,
        ST_BYTE2  = 3'b010,
        ST_EXEC   = 3'b011,
        ST_EXEC2  = 3'b100
    } cie_st_t;

    // Operations held in opcode bits 5:0
    typedef enum logic [5:0] {
        OP_NOP = 6'h00, OP_ADD = 6'h01, OP_ADC = 6'h02,
        OP_SUBTRACT_WITH_CARRY_OP = 6'h03, OP_AND = 6'h04, OP_OR = 6'h05,
        OP_XOR = 6'h06, OP_DO_IF_EQUAL = 6'h07, OP_DO_IF_NOT_EQUAL = 6'h08,
        OP_DO_IF_GREATER = 6'h09, OP_LOAD = 6'h0A, OP_EXCHANGE = 6'h0B,
        OP_AND_IMMEDIATE_SKIP_ZERO = 6'h0C, OP_DIRECT_EQUAL = 6'h0D,
        OP_POINTER_LOW_NIBBLE_COMPARE = 6'h0E, OP_DECREMENT_SKIP_ZERO = 6'h0F,
        OP_BIT_SET_OP = 6'h10, OP_BIT_CLEAR_OP = 6'h11, OP_BIT_TEST_OP = 6'h12,
        OP_CLEAR_SOFT_IRQ_PENDING = 6'h13, OP_LOAD_AUTO = 6'h14,
        OP_EXCHANGE_AUTO = 6'h15, OP_PROGRAM_BYTE_LOAD = 6'h16,
        OP_DECIMAL_ADJUST = 6'h17, OP_ROTATE_RIGHT_THROUGH_CARRY = 6'h18,
        OP_ROTATE_LEFT_THROUGH_CARRY = 6'h19, OP_SET_CARRY = 6'h1A,
        OP_RESET_CARRY = 6'h1B, OP_DO_IF_CARRY_SET = 6'h1C,
        OP_DO_IF_CARRY_CLEAR = 6'h1D, OP_PUSH = 6'h1E, OP_POP = 6'h1F,
        OP_VECTOR_TO_SERVICE = 6'h20, OP_SEGMENT_ABSOLUTE_JUMP = 6'h21,
        OP_SEGMENT_SUBROUTINE_CALL = 6'h22, OP_LONG_ABSOLUTE_JUMP = 6'h23,
        OP_LONG_SUBROUTINE_CALL = 6'h24, OP_SHORT_RELATIVE_JUMP = 6'h25,
        OP_TABLE_INDIRECT_JUMP = 6'h26, OP_SUB_RETURN = 6'h27,
        OP_INTERRUPT_RETURN = 6'h28
    } cie_op_t;

endpackage : cie_pkg

// ==== tb/cie_props.sv ====
`timescale 1ns/100ps
`default_nettype none
module cie_props (
    // Watched core ports
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic [14:0] pm_addr,
    input wire logic [7:0]  dm_addr,
    input wire logic        dm_we,
    input wire logic        int_enable_clear,
    input wire logic        global_interrupt_enable,
    input wire logic        clear_soft_irq_pending,
    input wire logic [7:0]  acc,
    input wire logic        carry,
    input wire logic        half_carry_flag
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Write cycle, then flags left alone
    sequence wr_s; dm_we; endsequence
    sequence held_s; $stable(carry) && $stable(half_carry_flag); endsequence
    rst_pc_clear_a: assert property (disable iff (1'b0) rst |=> pm_addr == 15'h0000)
        else $error("pc not cleared by reset");
    rst_flag_clear_a: assert property (
        disable iff (1'b0) rst |=> acc == 8'h00 && !carry && !half_carry_flag)
        else $error("core state not cleared by reset");
    pend_one_shot_a: assert property (
        clear_soft_irq_pending |=> !clear_soft_irq_pending)
        else $error("pending clear wider than one cycle");
    pend_no_side_a: assert property (
        clear_soft_irq_pending |-> !dm_we ##1 $stable(acc))
        else $error("pending clear touched memory or acc");
    write_flags_a: assert property (wr_s |=> held_s)
        else $error("flags moved by a memory write");
    ptr_write_a: assert property (
        dm_we |-> !(dm_addr inside {8'hFC, 8'hFD, 8'hFE}))
        else $error("write leaked to a core pointer");
    gie_fall_a: assert property (
        $fell(global_interrupt_enable) |-> $past(int_enable_clear) || $past(rst))
        else $error("enable dropped without cause");
    gie_rise_a: assert property (
        $rose(global_interrupt_enable) |-> !$past(rst) && !$past(dm_we))
        else $error("enable rose outside a return");
endmodule : cie_props
bind cie_core cie_props i_props (.clk_sys, .rst, .pm_addr, .dm_addr, .dm_we, .int_enable_clear,
    .global_interrupt_enable, .clear_soft_irq_pending, .acc, .carry, .half_carry_flag);
`default_nettype wire

// ==== tb/cie_mem.sv ====
`timescale 1ns/100ps
`default_nettype none
module cie_mem (
    // Clock and memory ports
    input  wire logic        clk_sys,
    input  wire logic [14:0] pm_addr,
    output logic      [7:0]  pm_data,
    input  wire logic [7:0]  dm_addr,
    input  wire logic [7:0]  dm_wdata,
    input  wire logic        dm_we,
    output logic      [7:0]  dm_rdata
);
    logic [7:0] pm [0:32767];
    logic [7:0] dm [0:255];
    // Asynchronous reads
    assign pm_data  = pm[pm_addr];
    assign dm_rdata = dm[dm_addr];
    // Writes land at the rising edge
    always @(posedge clk_sys) begin
        if (dm_we)
            dm[dm_addr] <= dm_wdata;
    end
endmodule : cie_mem
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic [14:0] vector_addr = 15'h3000;
    logic        int_enable_clear = 1'b0;
    logic [14:0] pm_addr;
    logic [7:0]  pm_data, dm_addr, dm_wdata, dm_rdata, acc;
    logic        dm_we, global_interrupt_enable, clear_soft_irq_pending, carry, half_carry_flag;
    int          miscompares = 0;
    int          compares = 0;
    int          pend_seen = 0;
    // Clock, core and memories
    initial forever #10 clk_sys = ~clk_sys;
    cie_core i_cie_core (.clk_sys, .rst, .pm_addr, .pm_data, .dm_addr, .dm_wdata, .dm_we,
        .dm_rdata, .vector_addr, .int_enable_clear, .global_interrupt_enable,
        .clear_soft_irq_pending, .acc, .carry, .half_carry_flag);
    cie_mem i_cie_mem (.clk_sys, .pm_addr, .pm_data, .dm_addr, .dm_wdata, .dm_we, .dm_rdata);
    // Count pending-clear pulses
    always @(posedge clk_sys) begin
        if (clear_soft_irq_pending === 1'b1)
            pend_seen <= pend_seen + 1;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic put(input int a, input logic [7:0] b[$]);
        foreach (b[k]) i_cie_mem.pm[a + k] = b[k];
    endtask : put
    task automatic go(input int n);
        rst = 1'b1;
        repeat (16) @(negedge clk_sys);
        rst = 1'b0;
        repeat (n) @(negedge clk_sys);
    endtask : go
    task automatic wipe;
        foreach (i_cie_mem.pm[k]) i_cie_mem.pm[k] = 8'h00;
    endtask : wipe
    // Carry arithmetic and flag effects
    task automatic t_arith;
        wipe;
        put(0, {8'h4A, 8'h0F, 8'h1A, 8'h42, 8'h01, 8'h41, 8'hF0});
        go(20);
        chk(acc, 8'h01);
        chk({6'h00, carry, half_carry_flag}, 8'h01);
        wipe;
        put(0, {8'h4A, 8'h10, 8'h1A, 8'h43, 8'h01});
        go(16);
        chk(acc, 8'h0F);
        chk({6'h00, carry, half_carry_flag}, 8'h02);
    endtask : t_arith
    // Every skip test but bit test and decrement-skip, each skipped add would change the checked acc
    task automatic t_skip;
        wipe;
        i_cie_mem.dm[8'h10] = 8'h5A;
        put(0, {8'h4A, 8'hF0, 8'h4C, 8'h0F, 8'h41, 8'h01, 8'h47, 8'hF0, 8'h41, 8'h02, 8'h1C,
                8'h41, 8'h04, 8'h49, 8'hF3, 8'h41, 8'h08, 8'h48, 8'hF2, 8'h41, 8'h10, 8'h1D,
                8'h41, 8'h20, 8'h49, 8'h11, 8'h41, 8'h40, 8'h8D, 8'h10, 8'h5A, 8'h41, 8'h01,
                8'h4E, 8'h00, 8'h41, 8'h80});
        go(80);
        chk(acc, 8'h53);
    endtask : t_skip
    // Jumps, stack, call, return and vector
    task automatic t_flow;
        wipe;
        put(15'h0000, {8'h23, 8'h12, 8'h34});
        put(15'h1234, {8'h4A, 8'h5A, 8'h1E, 8'h4A, 8'h00, 8'h1F, 8'h21, 8'h05, 8'h67});
        put(15'h1567, {8'h24, 8'h20, 8'h00, 8'h20});
        put(15'h2000, {8'h28});
        put(15'h3000, {8'h40, 8'h10});
        put(15'h4010, {8'h25, 8'h20});
        put(15'h4030, {8'h41, 8'h01});
        go(90);
        chk(acc, 8'h5B);
        chk(i_cie_mem.dm[8'h2F], 8'h6A);
        chk(i_cie_mem.dm[8'h2E], 8'h15);
        chk({7'h00, global_interrupt_enable}, 8'h01);
        int_enable_clear = 1'b1;
        @(negedge clk_sys);
        int_enable_clear = 1'b0;
        chk({7'h00, global_interrupt_enable}, 8'h00);
    endtask : t_flow
    // Bit ops, decrement-skip and pending clear
    task automatic t_bits;
        wipe;
        i_cie_mem.dm[8'h10] = 8'h01;
        i_cie_mem.dm[8'hF1] = 8'h01;
        put(0, {8'h90, 8'h07, 8'h10, 8'h91, 8'h00, 8'h10, 8'h92, 8'h07, 8'h10, 8'h41, 8'h01,
                8'h92, 8'h00, 8'h10, 8'h41, 8'h02, 8'h0F, 8'h01, 8'h41, 8'h04, 8'h13});
        pend_seen = 0;
        go(50);
        chk(i_cie_mem.dm[8'h10], 8'h80);
        chk(i_cie_mem.dm[8'hF1], 8'h00);
        chk(acc, 8'h01);
        chk(pend_seen[7:0], 8'h01);
    endtask : t_bits
    // Rotates, auto pointers, program byte, decimal adjust, table jump
    task automatic t_data;
        wipe;
        i_cie_mem.dm[8'h00] = 8'h99;
        i_cie_mem.dm[8'hFF] = 8'h5C;
        put(0, {8'h4A, 8'h81, 8'h1B, 8'h18, 8'h18, 8'h19, 8'h15, 8'h16, 8'h15, 8'hD4, 8'h17,
                8'h26});
        put(15'h0099, {8'h35});
        put(15'h003A, {8'h50});
        put(15'h0050, {8'h15, 8'hD4});
        go(40);
        chk(i_cie_mem.dm[8'h00], 8'h40);
        chk(i_cie_mem.dm[8'h01], 8'h35);
        chk(i_cie_mem.dm[8'h02], 8'h3A);
        chk(acc, 8'h5C);
        chk({7'h00, carry}, 8'h01);
    endtask : t_data
    task automatic report_and_stop;
        if (miscompares == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop
    // Main sequence and watchdog
    initial begin
        t_arith;
        t_skip;
        t_flow;
        t_bits;
        t_data;
        report_and_stop;
    end
    initial begin
        #100000;
        miscompares++;
        report_and_stop;
    end
endmodule : tb
`default_nettype wire
